// ### dv/local_vector_table_error_spurious_tb_top.sv
// Self-checking testbench for the vector table, error status and spurious block.
`timescale 1ns/1ps
module local_vector_table_error_spurious_tb_top;
	logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, slow = 1'b0, pin_a = 1'b0, pin_b = 1'b0;
	logic [9:0]  ev = 10'h000;
	logic [7:0]  tp = 8'h00, eoi_vector, dlv_vector, inta_vector, last_vec;
	logic        core_ack, eoi_valid, dlv_valid, inta_valid, inta_spur, isr_set;
	logic        sw_en, focus_off, last_spur;
	logic [2:0]  dlv_kind;
	logic [15:0] n_inta;
	int          bad_count = 0, n_checks = 0, cyc = 0;
	logic [10:0] dlv_seen = 11'h000;
	always #50 clk = ~clk;
	always @(posedge clk) if (dlv_valid) dlv_seen <= {dlv_kind, dlv_vector};
	lvtes_top #(.EXT_COUNT(4)) lvtes_top_i (.REF_CLK(clk), .NRST(nrst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .LOCAL_PIN_IRQ_A(pin_a), .LOCAL_PIN_IRQ_B(pin_b),
		.PERF_OVERFLOW(ev[0]), .THERMAL_EVENT(ev[1]), .EXT_EVENT(ev[5:2]),
		.SEND_ACCEPT_ERROR(ev[6]), .RECEIVE_ACCEPT_ERROR(ev[7]), .SENT_ILLEGAL_VECTOR(ev[8]),
		.RECEIVED_ILLEGAL_VECTOR(ev[9]), .CORE_ACK(core_ack), .TASK_PRIORITY(tp),
		.EOI_VALID(eoi_valid), .EOI_VECTOR(eoi_vector), .DLV_VALID(dlv_valid),
		.DLV_KIND(dlv_kind), .DLV_VECTOR(dlv_vector), .INTA_VALID(inta_valid),
		.INTA_VECTOR(inta_vector), .INTA_SPURIOUS(inta_spur), .ISR_SET(isr_set),
		.SW_ENABLE(sw_en), .FOCUS_CHECK_OFF(focus_off));
	lvtes_core_model lvtes_core_model_i (.ref_clk(clk), .nrst(nrst), .slow(slow),
		.dlv_valid(dlv_valid), .inta_valid(inta_valid), .inta_vector(inta_vector),
		.inta_spur(inta_spur), .isr_set(isr_set), .core_ack(core_ack),
		.eoi_valid(eoi_valid), .eoi_vector(eoi_vector), .last_vec(last_vec),
		.last_spur(last_spur), .n_inta(n_inta));
	// ==========================================================
	// Tasks
	task test_done();
		$display("Checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk
	task wait_int();
		logic [15:0] n0;
		n0 = n_inta;
		for (int i = 0; i < 40 && n_inta === n0; i++) @(posedge clk);
		chk({16'h0, n_inta}, {16'h0, n0 + 16'h1});
	endtask : wait_int
	task fire(input logic [9:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 10'h000;
		wait_int();
	endtask : fire
	// ==========================================================
	// Timeout and main sequence
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			test_done();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rdchk(lvtes_pkg::OFF_SPUR, 32'h000000ff);
		apb(1'b1, lvtes_pkg::OFF_PERF, 32'h00000040);
		rdchk(lvtes_pkg::OFF_PERF, 32'h00010040);
		apb(1'b1, lvtes_pkg::OFF_SPUR, 32'h000003e0);
		rdchk(lvtes_pkg::OFF_SPUR, 32'h000003e0);
		chk({30'h0, sw_en, focus_off}, 32'h3);
		rdchk(lvtes_pkg::OFF_EXT_FEAT, 32'h00040000);
		rdchk(12'h530, 32'h00010000);
		apb(1'b1, lvtes_pkg::OFF_PERF, 32'h00000040);
		apb(1'b1, lvtes_pkg::OFF_THERM, 32'h00000045);
		apb(1'b1, lvtes_pkg::OFF_ERR, 32'h00000030);
		apb(1'b1, 12'h510, 32'h00000061);
		fire(10'h001);
		chk({24'h0, last_vec}, 32'h40);
		slow <= 1'b1;
		fire(10'h008);
		chk({24'h0, last_vec}, 32'h61);
		slow <= 1'b0;
		tp <= 8'h40;
		fire(10'h002);
		chk({23'h0, last_spur, last_vec}, 32'h1e0);
		tp <= 8'h00;
		apb(1'b0, 12'h004, 32'h0);
		chk({31'h0, er}, 32'h1);
		wait_int();
		chk({24'h0, last_vec}, 32'h30);
		fire(10'h3c0);
		chk({24'h0, last_vec}, 32'h30);
		apb(1'b1, lvtes_pkg::OFF_ESR, 32'hffffffff);
		rdchk(lvtes_pkg::OFF_ESR, 32'h000000ec);
		apb(1'b1, lvtes_pkg::OFF_ESR, 32'h00000000);
		rdchk(lvtes_pkg::OFF_ESR, 32'h00000000);
		// An SMI entry offers vector zero whatever the entry holds.
		apb(1'b1, 12'h520, 32'h00000277);
		fire(10'h010);
		chk({21'h0, dlv_seen}, 32'h00000200);
		apb(1'b1, lvtes_pkg::OFF_PERF, 32'h00000005);
		fire(10'h001);
		chk({24'h0, last_vec}, 32'h30);
		apb(1'b1, lvtes_pkg::OFF_ESR, 32'h00000000);
		rdchk(lvtes_pkg::OFF_ESR, 32'h00000020);
		// A spurious answer sends no end of interrupt, so the level pin stays held back.
		tp <= 8'h50;
		apb(1'b1, lvtes_pkg::OFF_PIN_A, 32'h00008050);
		pin_a <= 1'b1;
		wait_int();
		chk({23'h0, last_spur, last_vec}, 32'h1e0);
		repeat (8) @(posedge clk);
		rdchk(lvtes_pkg::OFF_PIN_A, 32'h0000c050);
		chk({16'h0, n_inta}, 32'h00000008);
		apb(1'b1, lvtes_pkg::OFF_SPUR, 32'h00000000);
		rdchk(lvtes_pkg::OFF_PERF, 32'h00010005);
		test_done();
	end
endmodule : local_vector_table_error_spurious_tb_top

// ### dv/lvtes_core_model.sv
// Behavioural model of the core interrupt handler on the delivery port.
`timescale 1ns/1ps
module lvtes_core_model (
	input  wire logic        ref_clk,     // Core clock.
	input  wire logic        nrst,        // Reset, active low.
	input  wire logic        slow,        // High delays each acknowledge.
	input  wire logic        dlv_valid,   // Offer pending.
	input  wire logic        inta_valid,  // Acknowledge result.
	input  wire logic [7:0]  inta_vector, // Vector handed over.
	input  wire logic        inta_spur,   // Result is spurious.
	input  wire logic        isr_set,     // In-service set.
	output logic             core_ack,    // Accept the offer.
	output logic             eoi_valid,   // End of interrupt pulse.
	output logic      [7:0]  eoi_vector,  // Vector completed.
	output logic      [7:0]  last_vec,    // Last vector taken.
	output logic             last_spur,   // Last result was spurious.
	output logic      [15:0] n_inta       // Results taken.
);
	logic [2:0] wait_q;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			core_ack <= 1'b0;
			eoi_valid <= 1'b0;
			eoi_vector <= 8'h00;
			last_vec <= 8'h00;
			last_spur <= 1'b0;
			n_inta <= 16'h0000;
			wait_q <= 3'h0;
		end else begin
			core_ack <= 1'b0;
			eoi_valid <= 1'b0;
			eoi_vector <= ~eoi_vector;
			if (dlv_valid && !core_ack) begin
				wait_q <= wait_q + 3'h1;
				if (wait_q >= (slow ? 3'h3 : 3'h0)) begin
					core_ack <= 1'b1;
					wait_q <= 3'h0;
				end
			end
			if (inta_valid) begin
				last_vec <= inta_vector;
				last_spur <= inta_spur;
				n_inta <= n_inta + 16'h0001;
				// A spurious result is finished without an end of interrupt.
				if (isr_set && !inta_spur) begin
					eoi_valid <= 1'b1;
					eoi_vector <= inta_vector;
				end
			end
		end
	end
endmodule : lvtes_core_model

// ### rtl/lvtes_pkg.sv
// Constants for the local vector table, error status and spurious vector block.
package lvtes_pkg;
	// ==========================================================
	// Register offsets within the 4 KB window
	localparam logic [11:0] OFF_SPUR     = 12'h0f0;
	localparam logic [11:0] OFF_ESR      = 12'h280;
	localparam logic [11:0] OFF_THERM    = 12'h330;
	localparam logic [11:0] OFF_PERF     = 12'h340;
	localparam logic [11:0] OFF_PIN_A    = 12'h350;
	localparam logic [11:0] OFF_PIN_B    = 12'h360;
	localparam logic [11:0] OFF_ERR      = 12'h370;
	localparam logic [11:0] OFF_EXT_FEAT = 12'h4f0;
	localparam logic [11:0] OFF_EXT_BASE = 12'h500;
	localparam int          EXT_STRIDE_LSB = 4;
	// ==========================================================
	// Source slots
	localparam logic [3:0] SRC_THERM = 4'h0;
	localparam logic [3:0] SRC_PERF  = 4'h1;
	localparam logic [3:0] SRC_PIN_A = 4'h2;
	localparam logic [3:0] SRC_PIN_B = 4'h3;
	localparam logic [3:0] SRC_ERR   = 4'h4;
	localparam logic [3:0] SRC_EXT0  = 4'h5;
	localparam int         NUM_FIXED_SRC = 5;
	// ==========================================================
	// Field positions
	localparam int VEC_LSB  = 0;
	localparam int KIND_LSB = 8;
	localparam int DS_BIT   = 12;
	localparam int RIR_BIT  = 14;
	localparam int TRIG_BIT = 15;
	localparam int MASK_BIT = 16;
	localparam int ASE_BIT  = 8;
	localparam int FCC_BIT  = 9;
	localparam int EXT_CNT_LSB = 16;
	localparam int ERR_SAE = 2;
	localparam int ERR_RAE = 3;
	localparam int ERR_SIV = 5;
	localparam int ERR_RIV = 6;
	localparam int ERR_IRA = 7;
	// ==========================================================
	// Message kinds and vector limits
	localparam logic [2:0] KIND_FIXED  = 3'h0;
	localparam logic [2:0] KIND_SMI    = 3'h2;
	localparam logic [2:0] KIND_NMI    = 3'h4;
	localparam logic [2:0] KIND_EXTERNAL_INTERRUPT = 3'h7;
	localparam logic [7:0] VEC_MIN     = 8'h10;
	localparam logic [7:0] SPUR_VEC_RST = 8'hff;
	localparam logic [7:0] ESR_MASK    = 8'hec;
endpackage : lvtes_pkg

// ### rtl/lvtes_src.sv
// One interrupt source slot: request latch, delivery status and remote pending flag.
`timescale 1ns/1ps
module lvtes_src (
	input  wire logic ref_clk,    // Core clock.
	input  wire logic nrst,       // Asynchronous reset, active low.
	input  wire logic evt,        // Source event or level.
	input  wire logic level_mode, // High for a level sensitive fixed pin.
	input  wire logic enable,     // Unmasked and allowed.
	input  wire logic take,       // Core accepted or slot dropped.
	input  wire logic end_of_interrupt,        // End of interrupt for this slot.
	output logic      req,        // Request toward the arbiter.
	output logic      ds,         // Delivery pending flag.
	output logic      remote_pending_flag         // Remote pending flag.
);
	typedef struct packed {
		logic prev;
		logic pend;
		logic remote_pending_flag;
		logic ds;
	} lvtes_src_t;

	lvtes_src_t s_q;
	lvtes_src_t s_d;
	logic       raw;

	// Requests held while the flag is set stay latched, so nothing is lost.
	assign raw = level_mode ? evt : s_q.pend;
	assign req = raw & enable & ~s_q.remote_pending_flag;
	assign ds  = s_q.ds;
	assign remote_pending_flag = s_q.remote_pending_flag;

	always_comb begin
		s_d = s_q;
		s_d.prev = evt;
		if (take) begin
			s_d.pend = 1'b0;
		end
		if (evt & ~s_q.prev & ~level_mode) begin
			s_d.pend = 1'b1;
		end
		if (end_of_interrupt) begin
			s_d.remote_pending_flag = 1'b0;
		end
		if (take & level_mode) begin
			s_d.remote_pending_flag = 1'b1;
		end
		s_d.ds = req & ~take;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_rir_set_take:  assert property (take & level_mode |=> s_q.remote_pending_flag)
		else $error("Remote pending flag not set on level accept.");
	a_rir_clear_eoi: assert property (end_of_interrupt & ~take & s_q.remote_pending_flag |=> ~s_q.remote_pending_flag)
		else $error("Remote pending flag not cleared by end of interrupt.");
	a_rir_hold_req:  assert property (s_q.remote_pending_flag |-> ~req ##0 (level_mode | s_q.pend | ~$past(s_q.pend)))
		else $error("Request forwarded or dropped while remote pending.");
	a_ds_pending:    assert property (req & ~take |=> ds)
		else $error("Delivery status not set while pending.");
endmodule : lvtes_src

// ### rtl/lvtes_top.sv
// Local vector table entries, error status, spurious vector control and delivery.
// Function
// - Pin entry trigger bit picks edge or level handling when kind is fixed.
// - Level pin: remote pending set on accept, cleared by end of interrupt.
// - While remote pending, pin requests are held back but stay pending.
// - Counter overflow raises interrupt through its entry, gated by mask.
// - Thermal event raises interrupt through its entry, gated by mask.
// - Extended feature register reports extended entry count in bits 23:16.
// - Four extended entries sit at consecutive offsets from 500h.
// - Extended sources arrive routed from outside this block, one event line per entry.
// - A handling error whose bit is not yet accumulated raises an interrupt through the error entry.
// - Error status write copies accumulated errors and clears them; data unused.
// - Send accept error bit set when no unit took our message.
// - Receive accept error bit set when nobody took a received message.
// - Sent illegal vector bit set when sending an illegal vector.
// - Received illegal vector bit set when receiving an illegal vector.
// - Illegal register address bit set on unmapped access within the window.
// - Task priority at or above level during acknowledge of a fixed kind gives spurious vector.
// - Spurious delivery leaves in-service state untouched; no end of interrupt.
// - Software disable refuses fixed and external kinds, keeps pending state.
// - Software disable forces all mask bits set; clearing writes ignored.
// - Focus check bit at one disables focus checking.
// - Mask bit one blocks the source, zero allows it.
// - Kind codes: fixed 000, SMI 010, NMI 100, external 111.
// - Delivery status high while pending at core, clear after delivery.
// - Fixed vector below 16 is illegal and raises an illegal vector error.
`timescale 1ns/1ps
module lvtes_top #(
	parameter int EXT_COUNT = 4 // Number of extended entries.
) (
	input  wire logic        REF_CLK,                 // Core clock, 10 MHz.
	input  wire logic        NRST,                    // Asynchronous reset, active low.
	input  wire logic        PSEL,                    // APB select.
	input  wire logic        PENABLE,                 // APB enable.
	input  wire logic        PWRITE,                  // APB direction.
	input  wire logic [11:0] PADDR,                   // APB byte address.
	input  wire logic [31:0] PWDATA,                  // APB write data.
	output logic      [31:0] PRDATA,                  // APB read data.
	output logic             PREADY,                  // APB ready.
	output logic             PSLVERR,                 // APB error on unmapped access.
	input  wire logic        LOCAL_PIN_IRQ_A,         // Local pin A, asynchronous.
	input  wire logic        LOCAL_PIN_IRQ_B,         // Local pin B, asynchronous.
	input  wire logic        PERF_OVERFLOW,           // Counter overflow pulse.
	input  wire logic        THERMAL_EVENT,           // Thermal event pulse.
	input  wire logic [EXT_COUNT-1:0] EXT_EVENT,      // Extended events, one per entry.
	input  wire logic        SEND_ACCEPT_ERROR,       // Sent message not accepted.
	input  wire logic        RECEIVE_ACCEPT_ERROR,    // Received message not accepted.
	input  wire logic        SENT_ILLEGAL_VECTOR,     // Illegal vector on send.
	input  wire logic        RECEIVED_ILLEGAL_VECTOR, // Illegal vector on receive.
	input  wire logic        CORE_ACK,                // Core acknowledges offer.
	input  wire logic [7:0]  TASK_PRIORITY,           // Current task priority.
	input  wire logic        EOI_VALID,               // End of interrupt pulse.
	input  wire logic [7:0]  EOI_VECTOR,              // Vector being completed.
	output logic             DLV_VALID,               // Offer to core pending.
	output logic      [2:0]  DLV_KIND,                // Offered message kind.
	output logic      [7:0]  DLV_VECTOR,              // Offered vector.
	output logic             INTA_VALID,              // Acknowledge result pulse.
	output logic      [7:0]  INTA_VECTOR,             // Vector handed to core.
	output logic             INTA_SPURIOUS,           // Result is spurious.
	output logic             ISR_SET,                 // Set in-service for vector.
	output logic             SW_ENABLE,               // Software enable state.
	output logic             FOCUS_CHECK_OFF          // Focus checking disabled.
);
	localparam int NSRC = lvtes_pkg::NUM_FIXED_SRC + EXT_COUNT;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_OFFER = 2'b10
	} lvtes_state_t;

	typedef struct packed {
		logic [1:0]            pin_s1;
		logic [1:0]            pin_s2;
		logic [NSRC-1:0][7:0]  vec;
		logic [NSRC-1:0][2:0]  kind;
		logic [NSRC-1:0]       trig;
		logic [NSRC-1:0]       mask;
		logic [7:0]            spur_vec;
		logic                  software_enable;
		logic                  fcc;
		logic [7:0]            esr;
		logic [7:0]            err_acc;
		logic                  err_new;
		lvtes_state_t          state;
		logic [3:0]            sel;
		logic                  dlv_valid;
		logic [2:0]            dlv_kind;
		logic [7:0]            dlv_vec;
		logic                  inta_valid;
		logic [7:0]            inta_vec;
		logic                  inta_spur;
		logic                  isr_set;
		logic                  pready;
		logic [31:0]           prdata;
		logic                  pslverr;
	} lvtes_regs_t;

	lvtes_regs_t      s_q;
	lvtes_regs_t      s_d;
	logic [NSRC-1:0]  evt;
	logic [NSRC-1:0]  lvl;
	logic [NSRC-1:0]  en;
	logic [NSRC-1:0]  take;
	logic [NSRC-1:0]  end_of_interrupt;
	logic [NSRC-1:0]  req;
	logic [NSRC-1:0]  ds;
	logic [NSRC-1:0]  remote_pending_flag;
	logic [7:0]       err_evt;
	logic             setup;
	logic             done;
	logic [4:0]       dec;

	// ==========================================================
	// Address decode: {hit, slot}; slot 4'hf marks a non-entry register.
	function automatic logic [4:0] decode(input logic [11:0] a);
		logic [11:0] d;
		d = a - lvtes_pkg::OFF_EXT_BASE;
		unique case ({a[11:2], 2'b00})
			lvtes_pkg::OFF_THERM:    decode = {1'b1, lvtes_pkg::SRC_THERM};
			lvtes_pkg::OFF_PERF:     decode = {1'b1, lvtes_pkg::SRC_PERF};
			lvtes_pkg::OFF_PIN_A:    decode = {1'b1, lvtes_pkg::SRC_PIN_A};
			lvtes_pkg::OFF_PIN_B:    decode = {1'b1, lvtes_pkg::SRC_PIN_B};
			lvtes_pkg::OFF_ERR:      decode = {1'b1, lvtes_pkg::SRC_ERR};
			lvtes_pkg::OFF_SPUR:     decode = 5'h1f;
			lvtes_pkg::OFF_ESR:      decode = 5'h1f;
			lvtes_pkg::OFF_EXT_FEAT: decode = 5'h1f;
			default: begin
				if (a >= lvtes_pkg::OFF_EXT_BASE && 32'(d[11:lvtes_pkg::EXT_STRIDE_LSB]) <
				    EXT_COUNT && d[3:2] == 2'b00) begin
					decode = {1'b1, 4'(lvtes_pkg::SRC_EXT0 + d[7:lvtes_pkg::EXT_STRIDE_LSB])};
				end else begin
					decode = 5'h0f;
				end
			end
		endcase
	endfunction : decode

	assign setup = PSEL & ~PENABLE;
	assign done  = PSEL & PENABLE & s_q.pready;
	assign dec   = decode(PADDR);

	// ==========================================================
	// Source wiring
	// Extended sources arrive already routed: each source's own control register picks
	// its entry outside this block, which only sees one event line per entry.
	assign err_evt = {1'b0, RECEIVED_ILLEGAL_VECTOR, SENT_ILLEGAL_VECTOR,
	                  1'b0, RECEIVE_ACCEPT_ERROR, SEND_ACCEPT_ERROR, 2'b00};

	always_comb begin
		evt = '0;
		evt[lvtes_pkg::SRC_THERM] = THERMAL_EVENT;
		evt[lvtes_pkg::SRC_PERF]  = PERF_OVERFLOW;
		evt[lvtes_pkg::SRC_PIN_A] = s_q.pin_s2[0];
		evt[lvtes_pkg::SRC_PIN_B] = s_q.pin_s2[1];
		evt[lvtes_pkg::SRC_ERR]   = s_q.err_new;
		evt[NSRC-1:lvtes_pkg::NUM_FIXED_SRC] = EXT_EVENT;
		for (int i = 0; i < NSRC; i++) begin
			lvl[i] = s_q.trig[i] & (s_q.kind[i] == lvtes_pkg::KIND_FIXED) &
			         (4'(i) == lvtes_pkg::SRC_PIN_A || 4'(i) == lvtes_pkg::SRC_PIN_B);
			// Disabled state refuses fixed and external kinds but keeps latched requests.
			en[i]  = ~s_q.mask[i] & (s_q.software_enable | ~(s_q.kind[i] == lvtes_pkg::KIND_FIXED ||
			         s_q.kind[i] == lvtes_pkg::KIND_EXTERNAL_INTERRUPT));
			end_of_interrupt[i] = EOI_VALID & (EOI_VECTOR == s_q.vec[i]) & lvl[i];
		end
	end

	for (genvar g = 0; g < NSRC; g++) begin : g_src
		lvtes_src u_src (
			.ref_clk    (REF_CLK),
			.nrst       (NRST),
			.evt        (evt[g]),
			.level_mode (lvl[g]),
			.enable     (en[g]),
			.take       (take[g]),
			.end_of_interrupt        (end_of_interrupt[g]),
			.req        (req[g]),
			.ds         (ds[g]),
			.remote_pending_flag        (remote_pending_flag[g])
		);
	end

	// ==========================================================
	// Next state
	always_comb begin
		logic       found;
		logic [3:0] pick;
		found = 1'b0;
		pick  = '0;
		s_d   = s_q;
		take  = '0;
		s_d.pin_s1     = {LOCAL_PIN_IRQ_B, LOCAL_PIN_IRQ_A};
		s_d.pin_s2     = s_q.pin_s1;
		s_d.inta_valid = 1'b0;
		s_d.inta_spur  = 1'b0;
		s_d.isr_set    = 1'b0;
		s_d.pready     = setup;

		// Read data is taken in the setup cycle and held through the access phase.
		if (setup) begin
			s_d.prdata  = '0;
			s_d.pslverr = ~dec[4];
			if (dec[4] && dec[3:0] != 4'hf) begin
				s_d.prdata[lvtes_pkg::VEC_LSB +: 8]  = s_q.vec[dec[3:0]];
				s_d.prdata[lvtes_pkg::KIND_LSB +: 3] = s_q.kind[dec[3:0]];
				s_d.prdata[lvtes_pkg::DS_BIT]        = ds[dec[3:0]];
				s_d.prdata[lvtes_pkg::MASK_BIT]      = s_q.mask[dec[3:0]];
				if (dec[3:0] == lvtes_pkg::SRC_PIN_A || dec[3:0] == lvtes_pkg::SRC_PIN_B) begin
					s_d.prdata[lvtes_pkg::RIR_BIT]  = remote_pending_flag[dec[3:0]];
					s_d.prdata[lvtes_pkg::TRIG_BIT] = s_q.trig[dec[3:0]];
				end
			end else if ({PADDR[11:2], 2'b00} == lvtes_pkg::OFF_SPUR) begin
				s_d.prdata[7:0] = s_q.spur_vec;
				s_d.prdata[lvtes_pkg::ASE_BIT] = s_q.software_enable;
				s_d.prdata[lvtes_pkg::FCC_BIT] = s_q.fcc;
			end else if ({PADDR[11:2], 2'b00} == lvtes_pkg::OFF_ESR) begin
				s_d.prdata[7:0] = s_q.esr;
			end else if ({PADDR[11:2], 2'b00} == lvtes_pkg::OFF_EXT_FEAT) begin
				s_d.prdata[lvtes_pkg::EXT_CNT_LSB +: 8] = 8'(EXT_COUNT);
			end
		end

		if (done && PWRITE && dec[4]) begin
			if (dec[3:0] != 4'hf) begin
				s_d.vec[dec[3:0]]  = PWDATA[lvtes_pkg::VEC_LSB +: 8];
				s_d.kind[dec[3:0]] = PWDATA[lvtes_pkg::KIND_LSB +: 3];
				s_d.trig[dec[3:0]] = PWDATA[lvtes_pkg::TRIG_BIT];
				s_d.mask[dec[3:0]] = PWDATA[lvtes_pkg::MASK_BIT] | ~s_q.software_enable;
			end else if ({PADDR[11:2], 2'b00} == lvtes_pkg::OFF_SPUR) begin
				s_d.spur_vec = PWDATA[7:0];
				s_d.software_enable      = PWDATA[lvtes_pkg::ASE_BIT];
				s_d.fcc      = PWDATA[lvtes_pkg::FCC_BIT];
				if (!PWDATA[lvtes_pkg::ASE_BIT]) begin
					s_d.mask = '1;
				end
			end else if ({PADDR[11:2], 2'b00} == lvtes_pkg::OFF_ESR) begin
				s_d.esr     = s_q.err_acc & lvtes_pkg::ESR_MASK;
				s_d.err_acc = '0;
			end
		end

		// Delivery arbiter: lowest slot first.
		unique case (s_q.state)
			ST_IDLE: begin
				for (int i = NSRC - 1; i >= 0; i--) begin
					if (req[i]) begin
						found = 1'b1;
						pick  = 4'(i);
					end
				end
				if (found) begin
					if (s_q.kind[pick] == lvtes_pkg::KIND_FIXED &&
					    s_q.vec[pick] < lvtes_pkg::VEC_MIN) begin
						take[pick] = 1'b1;
						s_d.err_acc[lvtes_pkg::ERR_SIV] = 1'b1;
					end else begin
						s_d.state     = ST_OFFER;
						s_d.sel       = pick;
						s_d.dlv_valid = 1'b1;
						s_d.dlv_kind  = s_q.kind[pick];
						s_d.dlv_vec   = (s_q.kind[pick] == lvtes_pkg::KIND_SMI) ? 8'h00 :
						                s_q.vec[pick];
					end
				end
			end
			ST_OFFER: begin
				if (CORE_ACK) begin
					take[s_q.sel]  = 1'b1;
					s_d.state      = ST_IDLE;
					s_d.dlv_valid  = 1'b0;
					s_d.inta_valid = 1'b1;
					if (s_q.dlv_kind == lvtes_pkg::KIND_FIXED &&
					    TASK_PRIORITY[7:4] >= s_q.dlv_vec[7:4]) begin
						s_d.inta_vec  = s_q.spur_vec;
						s_d.inta_spur = 1'b1;
					end else begin
						s_d.inta_vec = s_q.dlv_vec;
						s_d.isr_set  = s_q.dlv_kind == lvtes_pkg::KIND_FIXED;
					end
				end
			end
		endcase

		if (done && !dec[4]) begin
			s_d.err_acc[lvtes_pkg::ERR_IRA] = 1'b1;
		end
		// New errors win over a simultaneous status write.
		s_d.err_acc = s_d.err_acc | err_evt;
		// Internal errors (illegal vector, bad address) must raise the error entry as well.
		s_d.err_new = |(s_d.err_acc & ~s_q.err_acc);
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			s_q          <= '0;
			s_q.mask     <= '1;
			s_q.spur_vec <= lvtes_pkg::SPUR_VEC_RST;
			s_q.state    <= ST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign PRDATA          = s_q.prdata;
	assign PREADY          = s_q.pready;
	assign PSLVERR         = s_q.pslverr;
	assign DLV_VALID       = s_q.dlv_valid;
	assign DLV_KIND        = s_q.dlv_kind;
	assign DLV_VECTOR      = s_q.dlv_vec;
	assign INTA_VALID      = s_q.inta_valid;
	assign INTA_VECTOR     = s_q.inta_vec;
	assign INTA_SPURIOUS   = s_q.inta_spur;
	assign ISR_SET         = s_q.isr_set;
	assign SW_ENABLE       = s_q.software_enable;
	assign FOCUS_CHECK_OFF = s_q.fcc;

	// ==========================================================
	// Checks
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);

	sequence apb_setup_s;
		PSEL & ~PENABLE;
	endsequence
	sequence apb_answer_s;
		PREADY ##1 ~PREADY;
	endsequence

	a_bus_ready_one: assert property (apb_setup_s |=> apb_answer_s)
		else $error("Ready not a single cycle after setup.");
	a_mask_forced:   assert property (~s_q.software_enable |-> &s_q.mask)
		else $error("Mask clear while software disabled.");
	a_spur_vector:   assert property (s_q.state == ST_OFFER && CORE_ACK &&
		s_q.dlv_kind == lvtes_pkg::KIND_FIXED && TASK_PRIORITY[7:4] >= s_q.dlv_vec[7:4]
		|=> INTA_VALID && INTA_SPURIOUS && INTA_VECTOR == $past(s_q.spur_vec))
		else $error("Spurious vector not delivered.");
	a_spur_no_isr:   assert property (INTA_SPURIOUS |-> ~ISR_SET)
		else $error("In-service set on spurious delivery.");
	a_esr_copy:      assert property (done && PWRITE && {PADDR[11:2], 2'b00} == lvtes_pkg::OFF_ESR
		|=> s_q.esr == ($past(s_q.err_acc) & lvtes_pkg::ESR_MASK))
		else $error("Error status not copied on write.");
	a_ira_flag:      assert property (done && !dec[4] |=> s_q.err_acc[lvtes_pkg::ERR_IRA])
		else $error("Illegal address not recorded.");
	// A fresh error must reach the request latch of the error slot two edges later.
	a_err_irq_new:   assert property (~s_q.err_new && |(s_d.err_acc & ~s_q.err_acc) |=>
		s_q.err_new ##1 g_src[lvtes_pkg::SRC_ERR].u_src.s_q.pend)
		else $error("New error raised no error request.");
	a_ill_vec_drop:  assert property (s_q.state == ST_IDLE && DLV_VALID == 1'b0 ##1
		(s_q.state == ST_OFFER) |-> !(DLV_KIND == lvtes_pkg::KIND_FIXED && DLV_VECTOR < lvtes_pkg::VEC_MIN))
		else $error("Illegal fixed vector offered to core.");
endmodule : lvtes_top
